//--- hw/motor_sup_pkg.sv
// Shared types and constants for the motor mode and protection supervisor.
// Assumes one 100 MHz control clock; samples arrive from logic on that clock.
package motor_sup_pkg;

   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_INACTIVE = 3'h1,
      MODE_ACTIVE = 3'h2,
      MODE_ERROR = 3'h4
   } mode_t;

   typedef enum logic [1:0] {
      RUN_OFFSET = 2'h1,
      RUN_DRIVE = 2'h2
   } run_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   localparam int DATA_W = 16;
   localparam int NUM_PWM = 6;

   typedef struct packed {
      logic start;
      logic stop;
      logic reset;
      logic err_set;
   } cmd_t;

   typedef struct packed {
      logic signed [DATA_W-1:0] iu;
      logic signed [DATA_W-1:0] iv;
      logic signed [DATA_W-1:0] iw;
      logic [DATA_W-1:0] vdc;
      logic signed [DATA_W-1:0] speed;
   } sample_t;

   typedef struct packed {
      logic [DATA_W-1:0] rated_current;
      logic [DATA_W-1:0] inverter_limit;
      logic [DATA_W-1:0] ov_limit;
      logic [DATA_W-1:0] uv_limit;
      logic [DATA_W-1:0] speed_limit;
   } limits_t;

   // ----------------------------------------
   // Error status layout
   // ----------------------------------------
   localparam int ERR_W = 6;
   localparam int FAULT_W = 4;
   localparam int ERR_OC_SW = 0;
   localparam int ERR_OV = 1;
   localparam int ERR_UV = 2;
   localparam int ERR_OS = 3;
   localparam int ERR_OC_HW = 4;
   localparam int ERR_USER = 5;
   localparam logic [ERR_W-1:0] ERR_RESET = 6'h00;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [DATA_W-1:0] LIMIT_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] OC_SCALE_Q8 = 16'h0200;
   localparam int OC_SCALE_SHIFT = 8;
   localparam int OFFSET_INTERVALS = 8;
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int MONITOR_PERIOD_US = 125;
   localparam int MONITOR_CYCLES = (MONITOR_PERIOD_US * 1000) / CLOCK_PERIOD_NS;

endpackage

//--- hw/protection_check.sv
// Fault comparators for the supervisor: phase currents, bus voltage, speed.
// Assumes the sample and limits are stable on the clock and i_eval is a pulse.
`timescale 1ns/1ps
module protection_check #(
   parameter int DATA_W = motor_sup_pkg::DATA_W
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Evaluation request
   input wire logic i_eval,
   input wire motor_sup_pkg::sample_t i_sample,
   input wire motor_sup_pkg::limits_t i_limits,
   input wire logic [DATA_W-1:0] i_oc_scale,
   // Results
   output logic [motor_sup_pkg::FAULT_W-1:0] o_fault,
   output logic [DATA_W-1:0] o_oc_limit
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [DATA_W-1:0] magnitude(input logic signed [DATA_W-1:0] v);
      logic [DATA_W-1:0] m;
      m = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
      return m;
   endfunction

   // ----------------------------------------
   // Overcurrent limit
   // ----------------------------------------
   logic [2*DATA_W-1:0] scaled;
   logic [DATA_W-1:0] derived;
   logic [DATA_W-1:0] oc_limit_next;

   always_comb begin
      scaled = i_limits.rated_current * i_oc_scale;
      // Saturate rather than wrap a large rating into a tiny limit
      if (|scaled[2*DATA_W-1:DATA_W+motor_sup_pkg::OC_SCALE_SHIFT]) begin
         derived = '1;
      end else begin
         derived = scaled[DATA_W+motor_sup_pkg::OC_SCALE_SHIFT-1:motor_sup_pkg::OC_SCALE_SHIFT];
      end
      oc_limit_next = (derived > i_limits.inverter_limit) ? i_limits.inverter_limit : derived;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_oc_limit <= motor_sup_pkg::LIMIT_RESET;
      end else begin
         o_oc_limit <= oc_limit_next;
      end
   end

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   logic [2:0] phase_over;
   logic signed [DATA_W-1:0] phase [3];

   assign phase[0] = i_sample.iu;
   assign phase[1] = i_sample.iv;
   assign phase[2] = i_sample.iw;

   for (genvar p = 0; p < 3; p++) begin : g_phase
      assign phase_over[p] = magnitude(phase[p]) > o_oc_limit;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_fault <= '0;
      end else if (i_eval) begin
         o_fault[motor_sup_pkg::ERR_OC_SW] <= |phase_over;
         o_fault[motor_sup_pkg::ERR_OV] <= i_sample.vdc > i_limits.ov_limit;
         o_fault[motor_sup_pkg::ERR_UV] <= i_sample.vdc < i_limits.uv_limit;
         o_fault[motor_sup_pkg::ERR_OS] <=
            magnitude(i_sample.speed) > i_limits.speed_limit;
      end else begin
         o_fault <= '0;
      end
   end

endmodule

//--- hw/motor_mode_supervisor.sv
// Top of the motor supervisor: system mode, run sequencing, fault latching
// and PWM gating toward the inverter stage.
// Assumes host commands are one-cycle pulses on i_clock; the hardware
// overcurrent pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
module motor_mode_supervisor #(
   parameter int DATA_W = motor_sup_pkg::DATA_W,
   parameter int NUM_PWM = motor_sup_pkg::NUM_PWM,
   parameter int MONITOR_CYCLES = motor_sup_pkg::MONITOR_CYCLES,
   parameter int OFFSET_INTERVALS = motor_sup_pkg::OFFSET_INTERVALS,
   parameter logic [DATA_W-1:0] OC_SCALE = motor_sup_pkg::OC_SCALE_Q8
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Host commands
   input wire motor_sup_pkg::cmd_t i_cmd,
   input wire logic i_limit_load,
   input wire motor_sup_pkg::limits_t i_limits,
   // Measurements
   input wire logic i_sample_valid,
   input wire motor_sup_pkg::sample_t i_sample,
   // Inverter side
   input wire logic i_hw_output_disable_input,
   input wire logic [NUM_PWM-1:0] i_pwm,
   output logic [NUM_PWM-1:0] o_pwm,
   output logic [NUM_PWM-1:0] o_pwm_oe,
   // Status
   output motor_sup_pkg::mode_t o_mode,
   output motor_sup_pkg::run_t o_run_mode,
   output logic o_run_enable,
   output logic o_limit_ack,
   output logic [motor_sup_pkg::ERR_W-1:0] o_error_status,
   output logic [DATA_W-1:0] o_oc_limit
);

   // ----------------------------------------
   // Mode decoding
   // ----------------------------------------
   function automatic logic mode_is_inactive(input motor_sup_pkg::mode_t m);
      return m == motor_sup_pkg::MODE_INACTIVE;
   endfunction

   function automatic logic mode_is_active(input motor_sup_pkg::mode_t m);
      return m == motor_sup_pkg::MODE_ACTIVE;
   endfunction

   function automatic logic mode_is_error(input motor_sup_pkg::mode_t m);
      return m == motor_sup_pkg::MODE_ERROR;
   endfunction

   // ----------------------------------------
   // Hardware overcurrent pin synchroniser
   // ----------------------------------------
   logic hw_oc_meta_reg;
   logic hw_oc_sync_reg;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         hw_oc_meta_reg <= 1'b0;
         hw_oc_sync_reg <= 1'b0;
      end else begin
         hw_oc_meta_reg <= i_hw_output_disable_input;
         hw_oc_sync_reg <= hw_oc_meta_reg;
      end
   end

   // ----------------------------------------
   // Monitoring interval timer
   // ----------------------------------------
   localparam int TICK_W = $clog2(MONITOR_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MONITOR_CYCLES - 1);

   logic [TICK_W-1:0] tick_count_reg;
   logic monitor_tick;

   // Free-running, so the check cadence does not hang on sample arrival
   assign monitor_tick = tick_count_reg == TICK_LAST;

   always_ff @(posedge i_clock) begin
      if (i_srst || monitor_tick) begin
         tick_count_reg <= '0;
      end else begin
         tick_count_reg <= tick_count_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // Latest sample
   // ----------------------------------------
   // Held so that the periodic check still sees data if samples stall
   motor_sup_pkg::sample_t sample_reg;
   logic eval_reg;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sample_reg <= '0;
      end else if (i_sample_valid) begin
         sample_reg <= i_sample;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         eval_reg <= 1'b0;
      end else begin
         eval_reg <= i_sample_valid || monitor_tick;
      end
   end

   // ----------------------------------------
   // Programmable limits
   // ----------------------------------------
   motor_sup_pkg::limits_t limits_reg;
   logic limit_load_ok;

   // Loading while running would let a limit move under a live motor
   assign limit_load_ok = i_limit_load && !mode_is_active(o_mode);

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         limits_reg <= '0;
      end else if (limit_load_ok) begin
         limits_reg <= i_limits;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_limit_ack <= 1'b0;
      end else begin
         o_limit_ack <= limit_load_ok;
      end
   end

   // ----------------------------------------
   // Command qualification
   // ----------------------------------------
   // Commands outside their own mode are dropped without trace
   logic start_ok;
   logic stop_ok;
   logic reset_ok;

   assign start_ok = i_cmd.start && !i_cmd.stop && mode_is_inactive(o_mode);
   assign stop_ok = i_cmd.stop && mode_is_active(o_mode);
   assign reset_ok = i_cmd.reset && mode_is_error(o_mode);

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   logic [motor_sup_pkg::FAULT_W-1:0] sw_fault;

   protection_check #(
      .DATA_W(DATA_W)
   ) u_check (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_eval(eval_reg),
      .i_sample(sample_reg),
      .i_limits(limits_reg),
      .i_oc_scale(OC_SCALE),
      .o_fault(sw_fault),
      .o_oc_limit(o_oc_limit)
   );

   // ----------------------------------------
   // Fault collection
   // ----------------------------------------
   logic [motor_sup_pkg::ERR_W-1:0] new_err;
   logic error_event;
   logic reset_event;

   always_comb begin
      new_err = '0;
      new_err[motor_sup_pkg::FAULT_W-1:0] = sw_fault;
      new_err[motor_sup_pkg::ERR_OC_HW] = hw_oc_sync_reg;
      new_err[motor_sup_pkg::ERR_USER] = i_cmd.err_set;
   end

   // Error only from detection or the explicit error-set command
   assign error_event = |new_err;
   assign reset_event = reset_ok;

   // A fault in the same cycle as the reset survives the clear
   logic [motor_sup_pkg::ERR_W-1:0] err_next;

   always_comb begin
      err_next = reset_event ? motor_sup_pkg::ERR_RESET : o_error_status;
      err_next = err_next | new_err;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_error_status <= motor_sup_pkg::ERR_RESET;
      end else begin
         o_error_status <= err_next;
      end
   end

   // ----------------------------------------
   // System mode
   // ----------------------------------------
   motor_sup_pkg::mode_t mode_next;

   always_comb begin
      mode_next = o_mode;
      unique case (o_mode)
         motor_sup_pkg::MODE_INACTIVE: begin
            if (start_ok) begin
               mode_next = motor_sup_pkg::MODE_ACTIVE;
            end
         end
         motor_sup_pkg::MODE_ACTIVE: begin
            if (stop_ok) begin
               mode_next = motor_sup_pkg::MODE_INACTIVE;
            end
         end
         motor_sup_pkg::MODE_ERROR: begin
            if (reset_ok) begin
               mode_next = motor_sup_pkg::MODE_INACTIVE;
            end
         end
      endcase
      // Error outranks every host command
      if (error_event) begin
         mode_next = motor_sup_pkg::MODE_ERROR;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_mode <= motor_sup_pkg::MODE_INACTIVE;
      end else begin
         o_mode <= mode_next;
      end
   end

   // ----------------------------------------
   // Run-mode sequencing
   // ----------------------------------------
   localparam int OFS_W = $clog2(OFFSET_INTERVALS + 1);
   localparam logic [OFS_W-1:0] OFS_LAST = OFS_W'(OFFSET_INTERVALS - 1);

   logic [OFS_W-1:0] offset_count_reg;
   logic running;
   logic offset_step;
   logic offset_done;

   assign running = mode_is_active(o_mode) && !error_event;
   assign offset_step = i_sample_valid && (o_run_mode == motor_sup_pkg::RUN_OFFSET);
   assign offset_done = offset_step && (offset_count_reg == OFS_LAST);

   always_ff @(posedge i_clock) begin
      if (i_srst || !running) begin
         offset_count_reg <= '0;
      end else if (offset_step && !offset_done) begin
         offset_count_reg <= offset_count_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst || !running) begin
         o_run_mode <= motor_sup_pkg::RUN_OFFSET;
      end else if (offset_done) begin
         o_run_mode <= motor_sup_pkg::RUN_DRIVE;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_run_enable <= 1'b0;
      end else begin
         o_run_enable <= running;
      end
   end

   // ----------------------------------------
   // PWM gating
   // ----------------------------------------
   // Drive only in the drive phase; low outputs turn every switch off
   logic pwm_drive;

   assign pwm_drive = running && (o_run_mode == motor_sup_pkg::RUN_DRIVE);

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_pwm <= '0;
      end else begin
         o_pwm <= pwm_drive ? i_pwm : '0;
      end
   end

   // Pins float on a hardware trip until a reset command clears the cause
   logic pin_float;

   assign pin_float = hw_oc_sync_reg || err_next[motor_sup_pkg::ERR_OC_HW];

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_pwm_oe <= '0;
      end else if (pin_float) begin
         o_pwm_oe <= '0;
      end else begin
         o_pwm_oe <= '1;
      end
   end

endmodule

//--- dv/inverter_stage_model.sv
// Inverter power stage seen from the gated PWM pins.
// Assumes gate-driver inputs with pull-downs; the bench commands trips.
`timescale 1ns/1ps
module inverter_stage_model #(
   parameter int NUM_PWM = 6
) (
   // Gated drive
   input wire logic [NUM_PWM-1:0] i_pwm,
   input wire logic [NUM_PWM-1:0] i_pwm_oe,
   input wire logic i_trip,
   // Stage side
   output logic [NUM_PWM-1:0] o_gate,
   output logic o_hw_output_disable_input
);
   // Released pins fall to the pull-down, never hold the last level
   assign o_gate = i_pwm & i_pwm_oe;
   assign o_hw_output_disable_input = i_trip;
endmodule

//--- dv/motor_mode_supervisor_sva.sv
// Port-level checks of the supervisor's mode, trip and gating timing.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module motor_mode_supervisor_sva #(
   parameter int DATA_W = 16,
   parameter int NUM_PWM = 6
) (
   // Inputs
   input wire logic i_clock,
   input wire logic i_srst,
   input wire motor_sup_pkg::cmd_t i_cmd,
   input wire logic i_limit_load,
   input wire logic i_sample_valid,
   input wire motor_sup_pkg::sample_t i_sample,
   input wire logic i_hw_output_disable_input,
   // Outputs
   input wire logic [NUM_PWM-1:0] o_pwm,
   input wire logic [NUM_PWM-1:0] o_pwm_oe,
   input wire motor_sup_pkg::mode_t o_mode,
   input wire motor_sup_pkg::run_t o_run_mode,
   input wire logic o_run_enable,
   input wire logic o_limit_ack,
   input wire logic [motor_sup_pkg::ERR_W-1:0] o_error_status,
   input wire logic [DATA_W-1:0] o_oc_limit
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   sequence s_pin_held;
      i_hw_output_disable_input [*3];
   endsequence
   sequence s_oc_hit;
      i_sample_valid && !i_sample.iu[DATA_W-1] && (i_sample.iu > o_oc_limit);
   endsequence
   property p_mode_legal;
      o_mode inside {motor_sup_pkg::MODE_INACTIVE, motor_sup_pkg::MODE_ACTIVE,
         motor_sup_pkg::MODE_ERROR};
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");
   property p_mode_cause;
      $changed(o_mode) && !$past(i_srst) |-> o_mode == motor_sup_pkg::MODE_ERROR ||
         (o_mode == motor_sup_pkg::MODE_ACTIVE && $past(i_cmd.start)) ||
         (o_mode == motor_sup_pkg::MODE_INACTIVE && ($past(i_cmd.stop) || $past(i_cmd.reset)));
   endproperty
   a_mode_cause: assert property (p_mode_cause) else $error("mode moved on no event");
   property p_start;
      i_cmd.start && !i_cmd.stop && o_mode == motor_sup_pkg::MODE_INACTIVE
         |=> o_mode != motor_sup_pkg::MODE_INACTIVE;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_stop;
      i_cmd.stop && o_mode == motor_sup_pkg::MODE_ACTIVE |=> o_mode != motor_sup_pkg::MODE_ACTIVE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");
   property p_err_set;
      i_cmd.err_set |=> o_mode == motor_sup_pkg::MODE_ERROR && o_error_status[5];
   endproperty
   a_err_set: assert property (p_err_set) else $error("error-set not taken");
   property p_reset_clears;
      i_cmd.reset && !i_cmd.err_set && o_mode == motor_sup_pkg::MODE_ERROR
         |=> !o_error_status[5];
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("status kept");
   property p_run_enable;
      o_run_enable |-> $past(o_mode) == motor_sup_pkg::MODE_ACTIVE;
   endproperty
   a_run_enable: assert property (p_run_enable) else $error("run outside active");
   property p_pwm_gate;
      o_pwm != '0 |-> $past(o_mode) == motor_sup_pkg::MODE_ACTIVE &&
         $past(o_run_mode) == motor_sup_pkg::RUN_DRIVE;
   endproperty
   a_pwm_gate: assert property (p_pwm_gate) else $error("pwm leaked");
   property p_oc_trip;
      s_oc_hit |-> ##3 o_error_status[0] && o_mode == motor_sup_pkg::MODE_ERROR && o_pwm == '0;
   endproperty
   a_oc_trip: assert property (p_oc_trip) else $error("overcurrent missed");
   property p_pin_trip;
      s_pin_held |-> ##1 o_pwm_oe == '0 && o_error_status[4] &&
         o_mode == motor_sup_pkg::MODE_ERROR;
   endproperty
   a_pin_trip: assert property (p_pin_trip) else $error("pin trip missed");
   property p_limit_ack;
      i_limit_load |=> o_limit_ack == ($past(o_mode) != motor_sup_pkg::MODE_ACTIVE);
   endproperty
   a_limit_ack: assert property (p_limit_ack) else $error("limit ack wrong");
endmodule

bind motor_mode_supervisor motor_mode_supervisor_sva #(.DATA_W(DATA_W), .NUM_PWM(NUM_PWM))
   sva_u (.i_clock, .i_srst, .i_cmd, .i_limit_load, .i_sample_valid, .i_sample,
   .i_hw_output_disable_input, .o_pwm, .o_pwm_oe, .o_mode, .o_run_mode, .o_run_enable,
   .o_limit_ack, .o_error_status, .o_oc_limit);

//--- dv/test_motor_mode_protection_supervisor.sv
// Self-checking bench for the motor mode and protection supervisor.
// Assumes shortened monitor and offset counts to keep the run brief.
`timescale 1ns/1ps
module test_motor_mode_protection_supervisor;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   motor_sup_pkg::cmd_t i_cmd = '0;
   logic i_limit_load = 1'b0;
   motor_sup_pkg::limits_t i_limits = '0;
   logic i_sample_valid = 1'b0;
   motor_sup_pkg::sample_t i_sample = '0;
   logic trip = 1'b0;
   logic i_hw_output_disable_input;
   logic [5:0] i_pwm = 6'h2a;
   logic [5:0] o_pwm, o_pwm_oe, gate;
   motor_sup_pkg::mode_t o_mode;
   motor_sup_pkg::run_t o_run_mode;
   logic o_run_enable, o_limit_ack;
   logic [5:0] o_error_status;
   logic [15:0] o_oc_limit;
   int fails = 0;
   int tests_run = 0;
   // Limit edge, then one past it, per fault: iu, vdc, speed
   logic [47:0] tbl [8] = '{48'hff6a012c000a, 48'h0097012c000a, 48'h000a0190000a,
      48'h000a0191000a, 48'h000a00c8000a, 48'h000a00c7000a, 48'h000a012c03e8,
      48'h000a012c03e9};

   always #5 i_clock = ~i_clock;

   motor_mode_supervisor #(.MONITOR_CYCLES(50), .OFFSET_INTERVALS(2)) dut_u (.i_clock,
      .i_srst, .i_cmd, .i_limit_load, .i_limits, .i_sample_valid, .i_sample,
      .i_hw_output_disable_input, .i_pwm, .o_pwm, .o_pwm_oe, .o_mode, .o_run_mode,
      .o_run_enable, .o_limit_ack, .o_error_status, .o_oc_limit);
   inverter_stage_model stage_u (.i_pwm(o_pwm), .i_pwm_oe(o_pwm_oe), .i_trip(trip),
      .o_gate(gate), .o_hw_output_disable_input(i_hw_output_disable_input));

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic send(input motor_sup_pkg::cmd_t c);
      i_cmd = c;
      step(1);
      i_cmd = '0;
      step(1);
   endtask
   task automatic load(input motor_sup_pkg::limits_t l, input logic ack, input logic [15:0] oc);
      i_limits = l;
      i_limit_load = 1'b1;
      step(1);
      i_limit_load = 1'b0;
      check(o_limit_ack, ack);
      step(1);
      check(o_oc_limit, oc);
   endtask
   // Result of a sample is read three cycles after it is taken
   task automatic samp(input logic [47:0] s);
      i_sample = {s[47:32], 32'h00000000, s[31:0]};
      i_sample_valid = 1'b1;
      step(1);
      i_sample_valid = 1'b0;
      step(3);
   endtask
   task automatic end_of_test();
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      step(2);
      i_srst = 1'b0;
      step(2);
      check(o_mode, motor_sup_pkg::MODE_INACTIVE);
      check(o_pwm_oe, 6'h3f);
      load({16'h0032, 16'h012c, 16'h0190, 16'h00c8, 16'h03e8}, 1'b1, 16'h0064);
      load({16'h0064, 16'h0096, 16'h0190, 16'h00c8, 16'h03e8}, 1'b1, 16'h0096);
      send(4'h4);
      check(o_mode, motor_sup_pkg::MODE_INACTIVE);
      send(4'h8);
      check(o_mode, motor_sup_pkg::MODE_ACTIVE);
      check(o_run_enable, 1'b1);
      load('0, 1'b0, 16'h0096);
      samp(48'h000a012c000a);
      check(o_run_mode, motor_sup_pkg::RUN_OFFSET);
      samp(48'h000a012c000a);
      check(o_run_mode, motor_sup_pkg::RUN_DRIVE);
      check(gate, 6'h2a);
      trip = 1'b1;
      step(4);
      check(gate, 6'h00);
      check(o_error_status, 6'h10);
      send(4'h2);
      check(o_mode, motor_sup_pkg::MODE_ERROR);
      trip = 1'b0;
      step(3);
      send(4'h2);
      check(o_error_status, 6'h00);
      step(2);
      check(o_pwm_oe, 6'h3f);
      for (int k = 0; k < 4; k++) begin
         send(4'h8);
         samp(tbl[2*k]);
         check(o_mode, motor_sup_pkg::MODE_ACTIVE);
         samp(tbl[2*k+1]);
         check(o_mode, motor_sup_pkg::MODE_ERROR);
         check(o_error_status, 6'h01 << k);
         check(o_pwm, 6'h00);
         samp(48'h000a012c000a);
         send(4'h2);
         check(o_mode, motor_sup_pkg::MODE_INACTIVE);
      end
      send(4'h1);
      check(o_error_status, 6'h20);
      send(4'h8);
      check(o_mode, motor_sup_pkg::MODE_ERROR);
      send(4'h2);
      send(4'h8);
      send(4'h4);
      check(o_mode, motor_sup_pkg::MODE_INACTIVE);
      load({16'h0064, 16'h0096, 16'h0100, 16'h00c8, 16'h03e8}, 1'b1, 16'h0096);
      step(60);
      check(o_error_status, 6'h02);
      check(o_mode, motor_sup_pkg::MODE_ERROR);
      end_of_test();
   end

   initial begin
      step(5000);
      fails++;
      end_of_test();
   end
endmodule
